// *** hdl/uepp_pkg.sv ***
// constants for the eprom read and program controller
package uepp_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int DEPTH = 4096;
	localparam int CLK_MHZ = 50;
	localparam int CLK_NS = 20;
	// program pulse, in milliseconds
	localparam int PULSE_NOM_MS = 50;
	localparam int PULSE_MAX_MS = 55;
	localparam int PULSE_CYC = PULSE_NOM_MS * 1000 * CLK_MHZ;
	localparam int PULSE_MAX_CYC = PULSE_MAX_MS * 1000 * CLK_MHZ;
	// setup and hold, in microseconds
	localparam int SETUP_US = 2;
	localparam int HOLD_US = 2;
	localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
	localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
	// read access time, in nanoseconds, rounded up to cycles
	localparam int ACCESS_NS = 450;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	// settle time after the supply is switched, in cycles
	localparam int VPP_SETTLE_CYC = 4;
	localparam int CNT_W = 22;
	localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_RD_WAIT = 3'b001,
		ST_PG_SETUP = 3'b010,
		ST_PG_PULSE = 3'b011,
		ST_PG_HOLD = 3'b100,
		ST_VPP_DOWN = 3'b101,
		ST_PG_VERIFY = 3'b110
	} uepp_state_e;
endpackage

// *** hdl/uepp_ctrl.sv ***
// host controller that reads and programs the eprom through its pins
`timescale 1ns/1ns
`default_nettype none
// Operation
// - on a shared bus the host keeps the strobe high on all but the device read.
// - in programming the host drives all eight data bits onto the data pins.
// - once address and data are stable the host applies one low pulse of 50 ms.
// - a program pulse never exceeds 55 ms.
// - locations may be programmed in any order.
// - several devices may be programmed together from the same address, data and pulse.
// - during programming a skipped device keeps its strobe high.
// - verify is an ordinary read after the supply is back at the low level.
module uepp_ctrl #(
	parameter int PULSE_CYCLES = uepp_pkg::PULSE_CYC,
	parameter int NUM_DEV = 2
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// user request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [NUM_DEV-1:0] req_dev_sel,
	input wire logic [uepp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [uepp_pkg::DATA_W-1:0] req_data,
	// user answer
	output logic rsp_valid,
	output logic [uepp_pkg::DATA_W-1:0] rsp_data,
	output logic rsp_mismatch,
	// device pins
	output logic [uepp_pkg::ADDR_W-1:0] eprom_addr,
	output logic [NUM_DEV-1:0] power_down_program_strobe,
	output logic vpp_high,
	input wire logic [uepp_pkg::DATA_W-1:0] data_in,
	output logic [uepp_pkg::DATA_W-1:0] data_out,
	output logic data_oe
);
	// pulse clipped to the ceiling whatever the parameter asks
	localparam int PULSE_USE = (PULSE_CYCLES < uepp_pkg::PULSE_MAX_CYC) ?
		PULSE_CYCLES : uepp_pkg::PULSE_MAX_CYC;
	localparam logic [uepp_pkg::CNT_W-1:0] PULSE_LAST = uepp_pkg::CNT_W'(PULSE_USE - 1);
	localparam logic [uepp_pkg::CNT_W-1:0] SETUP_LAST = uepp_pkg::CNT_W'(uepp_pkg::SETUP_CYC - 1);
	localparam logic [uepp_pkg::CNT_W-1:0] HOLD_LAST = uepp_pkg::CNT_W'(uepp_pkg::HOLD_CYC - 1);
	localparam logic [uepp_pkg::CNT_W-1:0] ACC_LAST =
		uepp_pkg::CNT_W'(uepp_pkg::ACCESS_CYC + 1);
	localparam logic [uepp_pkg::CNT_W-1:0] SETTLE_LAST =
		uepp_pkg::CNT_W'(uepp_pkg::VPP_SETTLE_CYC - 1);

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	logic [uepp_pkg::DATA_W-1:0] din_s1_r;
	logic [uepp_pkg::DATA_W-1:0] din_s2_r;
	always_ff @(posedge clk)
	begin
		din_s1_r <= data_in;
		din_s2_r <= din_s1_r;
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	uepp_pkg::uepp_state_e state_r, state_nxt;
	logic [uepp_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [uepp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
	logic [uepp_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
	logic [NUM_DEV-1:0] sel_r, sel_nxt;
	logic [NUM_DEV-1:0] strobe_r, strobe_nxt;
	logic vpp_r, vpp_nxt;
	logic oe_r, oe_nxt;
	logic rsp_valid_r, rsp_valid_nxt;
	logic [uepp_pkg::DATA_W-1:0] rsp_data_r, rsp_data_nxt;
	logic mism_r, mism_nxt;

	function automatic logic cnt_done(input logic [uepp_pkg::CNT_W-1:0] c,
		input logic [uepp_pkg::CNT_W-1:0] last);
		cnt_done = (c >= last);
	endfunction

	// one-hot of the lowest selected device
	function automatic logic [NUM_DEV-1:0] lowest_sel(input logic [NUM_DEV-1:0] s);
		lowest_sel = s & (~s + 1'b1);
	endfunction

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + 1'b1;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		sel_nxt = sel_r;
		strobe_nxt = strobe_r;
		vpp_nxt = vpp_r;
		oe_nxt = oe_r;
		rsp_valid_nxt = 1'b0;
		rsp_data_nxt = rsp_data_r;
		mism_nxt = mism_r;
		unique case (state_r)
			uepp_pkg::ST_IDLE:
			begin
				cnt_nxt = '0;
				// all strobes high: every device disabled
				strobe_nxt = '1;
				if (req_valid)
				begin
					addr_nxt = req_addr;
					wdata_nxt = req_data;
					sel_nxt = req_dev_sel;
					if (req_write)
					begin
						vpp_nxt = 1'b1;
						oe_nxt = 1'b1;
						state_nxt = uepp_pkg::ST_PG_SETUP;
					end
					else
					begin
						// only the first selected device is read
						strobe_nxt = ~lowest_sel(req_dev_sel);
						state_nxt = uepp_pkg::ST_RD_WAIT;
					end
				end
			end
			uepp_pkg::ST_RD_WAIT:
			begin
				// access time plus the two synchroniser stages
				if (cnt_done(cnt_r, ACC_LAST))
				begin
					rsp_data_nxt = din_s2_r;
					mism_nxt = 1'b0;
					rsp_valid_nxt = 1'b1;
					strobe_nxt = '1;
					state_nxt = uepp_pkg::ST_IDLE;
				end
			end
			uepp_pkg::ST_PG_SETUP:
			begin
				if (cnt_done(cnt_r, SETUP_LAST))
				begin
					cnt_nxt = '0;
					strobe_nxt = ~sel_r;
					state_nxt = uepp_pkg::ST_PG_PULSE;
				end
			end
			uepp_pkg::ST_PG_PULSE:
			begin
				// pulse length bounded by parameter, never past 55 ms
				if (cnt_done(cnt_r, PULSE_LAST))
				begin
					cnt_nxt = '0;
					strobe_nxt = '1;
					state_nxt = uepp_pkg::ST_PG_HOLD;
				end
			end
			uepp_pkg::ST_PG_HOLD:
			begin
				if (cnt_done(cnt_r, HOLD_LAST))
				begin
					cnt_nxt = '0;
					oe_nxt = 1'b0;
					vpp_nxt = 1'b0;
					state_nxt = uepp_pkg::ST_VPP_DOWN;
				end
			end
			uepp_pkg::ST_VPP_DOWN:
			begin
				if (cnt_done(cnt_r, SETTLE_LAST))
				begin
					cnt_nxt = '0;
					strobe_nxt = ~lowest_sel(sel_r);
					state_nxt = uepp_pkg::ST_PG_VERIFY;
				end
			end
			uepp_pkg::ST_PG_VERIFY:
			begin
				// verify is a plain read at the low supply
				if (cnt_done(cnt_r, ACC_LAST))
				begin
					rsp_data_nxt = din_s2_r;
					// a one asked over a zero cannot be set
					mism_nxt = (din_s2_r != wdata_r);
					rsp_valid_nxt = 1'b1;
					strobe_nxt = '1;
					state_nxt = uepp_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = uepp_pkg::ST_IDLE;
				strobe_nxt = '1;
				vpp_nxt = 1'b0;
				oe_nxt = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// sequencer registers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= uepp_pkg::ST_IDLE;
			cnt_r <= '0;
			addr_r <= '0;
			wdata_r <= '0;
			sel_r <= '0;
			strobe_r <= '1;
			vpp_r <= 1'b0;
			oe_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r <= '0;
			mism_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			sel_r <= sel_nxt;
			strobe_r <= strobe_nxt;
			vpp_r <= vpp_nxt;
			oe_r <= oe_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r <= rsp_data_nxt;
			mism_r <= mism_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// only idle takes a request
	assign req_ready = (state_r == uepp_pkg::ST_IDLE) && !rst;
	assign rsp_valid = rsp_valid_r;
	assign rsp_data = rsp_data_r;
	assign rsp_mismatch = mism_r;
	// static levels only, no clock toward the device
	assign eprom_addr = addr_r;
	assign power_down_program_strobe = strobe_r;
	assign vpp_high = vpp_r;
	assign data_out = wdata_r;
	assign data_oe = oe_r;
endmodule // uepp_ctrl
`default_nettype wire

// *** tb/uepp_ctrl_asserts.sv ***
// pin-level checks on the eprom controller
`timescale 1ns/1ns
`default_nettype none
module uepp_ctrl_asserts #(
	parameter int PULSE_CYCLES = 40,
	parameter int NUM_DEV = 2
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [NUM_DEV-1:0] req_dev_sel,
	// pins
	input wire logic [uepp_pkg::ADDR_W-1:0] eprom_addr,
	input wire logic [NUM_DEV-1:0] power_down_program_strobe,
	input wire logic vpp_high,
	input wire logic [uepp_pkg::DATA_W-1:0] data_out,
	input wire logic data_oe
);
	logic [NUM_DEV-1:0] on;
	logic [NUM_DEV-1:0] sel_r;
	logic [31:0] cnt_r;
	logic low;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	assign on = ~power_down_program_strobe;
	assign low = vpp_high && (on != '0);
	// length of the current program pulse
	always_ff @(posedge clk)
	begin
		cnt_r <= (rst || !low) ? '0 : cnt_r + 1;
		if (req_valid && req_ready)
			sel_r <= req_dev_sel;
	end
	AST_ADDR_HOLD: assert property (low |-> $stable(eprom_addr))
		else $error("address moved in pulse");
	AST_DATA_DRIVE: assert property (low |-> data_oe && $stable(data_out))
		else $error("data not held in pulse");
	AST_ONE_READER: assert property (!vpp_high |-> $countones(on) <= 1)
		else $error("two devices enabled");
	AST_NO_FIGHT: assert property (!vpp_high && on != '0 |-> !data_oe)
		else $error("host drives during read");
	AST_PULSE_LEN: assert property (!low && cnt_r != 0 |-> cnt_r == PULSE_CYCLES)
		else $error("pulse length wrong");
	AST_PULSE_CAP: assert property (cnt_r <= PULSE_CYCLES)
		else $error("pulse too long");
	AST_ALL_SELECTED: assert property (low |-> on == sel_r)
		else $error("selected devices not pulsed together");
	AST_SKIPPED_HIGH: assert property (vpp_high |-> (on & ~sel_r) == '0)
		else $error("skipped device pulsed");
endmodule // uepp_ctrl_asserts
bind uepp_ctrl uepp_ctrl_asserts #(.PULSE_CYCLES(PULSE_CYCLES), .NUM_DEV(NUM_DEV)) i_uepp_ctrl_asserts
	(.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
	.req_dev_sel(req_dev_sel), .eprom_addr(eprom_addr), .vpp_high(vpp_high),
	.power_down_program_strobe(power_down_program_strobe), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// *** tb/uepp_eprom_model.sv ***
// behavioural model of one eprom
`timescale 1ns/1ns
`default_nettype none
module uepp_eprom_model
(
	// pins
	input wire logic [11:0] addr,
	input wire logic strobe,
	input wire logic vpp,
	input wire logic [7:0] din,
	output logic [7:0] q,
	output logic q_en
);
	logic [7:0] mem [4096];
	initial foreach (mem[i]) mem[i] = uepp_pkg::ERASED_BYTE;
	assign q_en = !strobe && !vpp;
	assign q = mem[addr];
	always @(posedge strobe)
		if (vpp)
			mem[addr] <= mem[addr] & din;
endmodule // uepp_eprom_model
`default_nettype wire

// *** tb/uepp_ctrl_test.sv ***
// self-checking bench for the eprom controller
`timescale 1ns/1ns
`default_nettype none
module uepp_ctrl_test;
	logic clk = 0, rst = 1, req_valid = 0, req_write = 0;
	logic req_ready, rsp_valid, rsp_mismatch, vpp_high, data_oe, mm;
	logic [1:0] req_dev_sel = 0, pds, en;
	logic [11:0] req_addr = 0, eprom_addr;
	logic [7:0] req_data = 0, rsp_data, data_in, data_out, q0, q1, last, got;
	int mismatches = 0, compares = 0, cyc = 0;
	uepp_ctrl #(.PULSE_CYCLES(40)) i_uepp_ctrl(.clk(clk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_dev_sel(req_dev_sel),
		.req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_mismatch(rsp_mismatch), .eprom_addr(eprom_addr), .power_down_program_strobe(pds),
		.vpp_high(vpp_high), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
	uepp_eprom_model i_uepp_eprom_model_a(.addr(eprom_addr), .strobe(pds[0]), .vpp(vpp_high),
		.din(data_in), .q(q0), .q_en(en[0]));
	uepp_eprom_model i_uepp_eprom_model_b(.addr(eprom_addr), .strobe(pds[1]), .vpp(vpp_high),
		.din(data_in), .q(q1), .q_en(en[1]));
	// released bus shows a changing pattern
	assign data_in = en[0] ? q0 : en[1] ? q1 : data_oe ? data_out : ~last;
	always @(posedge clk) last <= data_in;
	initial forever #10 clk = ~clk;
	always @(posedge clk)
		if (++cyc == 30000)
		begin
			mismatches++;
			report_and_stop;
		end
	task report_and_stop;
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected at %0t: %h not %h", $time, s, e);
		end
	endtask
	task acc(input logic w, input logic [1:0] s, input logic [11:0] a, input logic [7:0] d);
		logic ok;
		req_valid = 1;
		req_write = w;
		req_dev_sel = s;
		req_addr = a;
		req_data = d;
		do begin ok = req_ready; @(posedge clk); #1; end while (ok !== 1'b1);
		req_valid = 0;
		do begin @(posedge clk); #1; end while (rsp_valid !== 1'b1);
		got = rsp_data;
		mm = rsp_mismatch;
	endtask
	task t_program;
		acc(0, 2'h1, 12'hfff, 8'h00);
		chk(got, 8'hff);
		acc(1, 2'h1, 12'h123, 8'ha5);
		chk({7'h00, mm}, 8'h00);
		acc(0, 2'h1, 12'h123, 8'h00);
		chk(got, 8'ha5);
		acc(0, 2'h2, 12'h123, 8'h00);
		chk(got, 8'hff);
	endtask
	task t_parallel;
		acc(1, 2'h3, 12'h000, 8'h3c);
		chk({7'h00, mm}, 8'h00);
		acc(0, 2'h1, 12'h000, 8'h00);
		chk(got, 8'h3c);
		acc(0, 2'h2, 12'h000, 8'h00);
		chk(got, 8'h3c);
	endtask
	task t_zero;
		acc(1, 2'h1, 12'h123, 8'hff);
		chk({7'h00, mm}, 8'h01);
		acc(0, 2'h1, 12'h123, 8'h00);
		chk(got, 8'ha5);
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		#1;
		rst = 0;
		t_program;
		t_parallel;
		t_zero;
		report_and_stop;
	end
endmodule // uepp_ctrl_test
`default_nettype wire
